// *** design/bpr_port_block.sv ***
// Port register block of a multiplexed external bus: ports A, B, E, K and controls.
// Assumes a synchronous register port and pin inputs synchronous to core_clk.
//
// Our own choice: the address-and-strobe port.
`include "bpr_defines.svh"
`timescale 1ns/1ns
`default_nettype none

module bpr_port_block #(
  parameter int         ADDR_W      = 16,
  parameter logic [7:0] PE_PULL_UP  = 8'h9F
) (
  input  wire logic              core_clk,
  input  wire logic              reset,
  // Register port
  input  wire logic [ADDR_W-1:0] reg_base,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [7:0]        reg_rdata,
  // Ports A, B and K
  input  wire logic [7:0]        pa_in,
  output logic      [7:0]        pa_out,
  output logic      [7:0]        pa_oe,
  input  wire logic [7:0]        pb_in,
  output logic      [7:0]        pb_out,
  output logic      [7:0]        pb_oe,
  input  wire logic [7:0]        pk_in,
  output logic      [7:0]        pk_out,
  output logic      [7:0]        pk_oe,
  // Port E pads
  input  wire logic [7:0]        pe_in,
  output logic      [7:0]        pe_out,
  output logic      [7:0]        pe_oe,
  output logic      [7:0]        pe_pull_en,
  output logic      [7:0]        pe_pull_up,
  // Bus function sources
  input  wire logic [1:0]        bus_pipe,
  input  wire logic              bus_eclk,
  input  wire logic              bus_strobe_n,
  input  wire logic              bus_rw,
  // Interrupt requests
  output logic                   irq_req_n,
  output logic                   nonmaskable_interrupt_request_req_n,
  // Register contents
  output logic      [7:0]        mode_value,
  output logic      [7:0]        rdrive_value,
  output logic      [7:0]        ebus_value,
  output logic      [7:0]        irq_ctl_value,
  // External echo
  output logic                   echo_rd,
  output logic                   echo_wr,
  output logic      [5:0]        echo_ofs,
  output logic      [7:0]        echo_wdata
);

  // Refuse an address bus too narrow for the register span
  if (ADDR_W < 7 || ADDR_W > 32) begin : g_chk
    $error("bpr_port_block: ADDR_W must be 7 to 32");
  end

  // Pins 6:5 carry no pull device; a polarity there means nothing
  localparam logic [7:0] PULL_CAPABLE = 8'h9F;
  if ((PE_PULL_UP & ~PULL_CAPABLE) != 8'h00) begin : g_chk_pull
    $error("bpr_port_block: PE_PULL_UP names pins without pulls");
  end

  bpr_pkg::bpr_state_t st_reg;
  bpr_pkg::bpr_state_t st_next;

  // Address decode
  logic [ADDR_W-1:0] rel_addr;
  logic              in_span;
  logic [5:0]        ofs;
  logic              wr_ok;
  logic              rd_ok;

  // One select per implemented register
  logic              hit_pa_val;
  logic              hit_pb_val;
  logic              hit_pa_dir;
  logic              hit_pb_dir;
  logic              hit_pe_val;
  logic              hit_pe_dir;
  logic              hit_pe_asgn;
  logic              hit_mode;
  logic              hit_pull;
  logic              hit_rdrive;
  logic              hit_ebus;
  logic              hit_irq_ctl;
  logic              hit_pk_val;
  logic              hit_pk_dir;

  // Mode and map state
  logic [2:0]        mode_code;
  logic              periph_mode;
  logic              expanded;
  logic              pe_unmapped;
  logic              rsv_hit;
  logic              unmapped;

  // Per-bit port views
  logic [7:0]        pe_special;
  logic [7:0]        pe_spec_val;
  wire logic [7:0]   pe_rd_val;
  wire logic [7:0]   pe_inputs;
  wire logic [7:0]   pe_drv_en;
  wire logic [7:0]   pe_drv_val;
  wire logic [7:0]   pe_pull_sel;
  wire logic [7:0]   pa_rd_val;
  wire logic [7:0]   pb_rd_val;
  wire logic [7:0]   pk_rd_val;

  // Offset from the relocatable base
  assign rel_addr = reg_addr - reg_base;
  assign in_span  = rel_addr < ADDR_W'(`BPR_SPAN);
  assign ofs      = rel_addr[5:0];

  // Register selects within the span
  assign hit_pa_val  = ofs == `BPR_OFS_PA_VAL;
  assign hit_pb_val  = ofs == `BPR_OFS_PB_VAL;
  assign hit_pa_dir  = ofs == `BPR_OFS_PA_DIR;
  assign hit_pb_dir  = ofs == `BPR_OFS_PB_DIR;
  assign hit_pe_val  = ofs == `BPR_OFS_PE_VAL;
  assign hit_pe_dir  = ofs == `BPR_OFS_PE_DIR;
  assign hit_pe_asgn = ofs == `BPR_OFS_PE_ASGN;
  assign hit_mode    = ofs == `BPR_OFS_MODE;
  assign hit_pull    = ofs == `BPR_OFS_PULL;
  assign hit_rdrive  = ofs == `BPR_OFS_RDRIVE;
  assign hit_ebus    = ofs == `BPR_OFS_EBUS;
  assign hit_irq_ctl = ofs == `BPR_OFS_IRQ_CTL;
  assign hit_pk_val  = ofs == `BPR_OFS_PK_VAL;
  assign hit_pk_dir  = ofs == `BPR_OFS_PK_DIR;

  // Mode decode
  assign mode_code   = st_reg.mode[`BPR_MODE_HI:`BPR_MODE_LO];
  assign periph_mode = mode_code == `BPR_MODE_PERIPH;
  assign expanded    = !periph_mode && mode_code != `BPR_MODE_SS
                       && mode_code != `BPR_MODE_NS;
  assign pe_unmapped = periph_mode
                       || (expanded && st_reg.mode[`BPR_MODE_EME]);
  assign rsv_hit     = (ofs >= `BPR_OFS_RSV_LO && ofs <= `BPR_OFS_RSV_HI)
                       || ofs == `BPR_OFS_RSV_F;

  // Accesses that leave the on-chip map and go outside
  assign unmapped = in_span && ((rsv_hit && periph_mode)
                    || (hit_pe_val && pe_unmapped));

  // Accesses that stay on chip; others are ignored or echoed
  assign wr_ok = reg_wr && in_span && !unmapped;
  assign rd_ok = reg_rd && in_span && !unmapped;

  // Pins given over to bus functions by the assignment register
  assign pe_special = {1'b0,
                       st_reg.pe_asgn[`BPR_ASGN_PIPE],
                       st_reg.pe_asgn[`BPR_ASGN_PIPE],
                       ~st_reg.pe_asgn[`BPR_ASGN_NOCLK],
                       st_reg.pe_asgn[`BPR_ASGN_STRB],
                       st_reg.pe_asgn[`BPR_ASGN_RW],
                       2'b00};
  assign pe_spec_val = {1'b0, bus_pipe, bus_eclk,
                        bus_strobe_n, bus_rw, 2'b00};

  // Per-bit port E decode: sense, drive, read source, pull
  for (genvar b = 0; b < 8; b++) begin : g_pe_bit
    if (b < 2) begin : g_in_only
      // Interrupt pins only ever sense
      assign pe_inputs[b]  = 1'b1;
      assign pe_drv_en[b]  = 1'b0;
      assign pe_drv_val[b] = 1'b0;
    end else begin : g_io
      // Bus function wins; otherwise the direction bit decides
      assign pe_inputs[b]  = !pe_special[b] && !st_reg.pe_dir[b];
      assign pe_drv_en[b]  = pe_special[b] || st_reg.pe_dir[b];
      assign pe_drv_val[b] = pe_special[b] ? pe_spec_val[b]
                                           : st_reg.pe_val[b];
    end
    // Read source: pin while sensing, output latch while driving
    assign pe_rd_val[b] = pe_inputs[b] ? pe_in[b] : st_reg.pe_val[b];
    // One enable for all pull-capable pins, only while they sense
    assign pe_pull_sel[b] = st_reg.pull[`BPR_PULL_PE] && pe_inputs[b]
                            && PULL_CAPABLE[b];
  end

  // Ports A, B and K read back: pin when sensing, latch when driving
  for (genvar b = 0; b < 8; b++) begin : g_gp_bit
    // Port A
    assign pa_rd_val[b] = st_reg.pa_dir[b] ? st_reg.pa_val[b] : pa_in[b];
    // Port B
    assign pb_rd_val[b] = st_reg.pb_dir[b] ? st_reg.pb_val[b] : pb_in[b];
    // Port K
    assign pk_rd_val[b] = st_reg.pk_dir[b] ? st_reg.pk_val[b] : pk_in[b];
  end

  // Next state: register writes, read data, pin drive
  always_comb begin
    st_next       = st_reg;
    st_next.rdata = 8'h00;

    // Register writes; reserved and unlisted offsets ignore them
    if (wr_ok) begin
      if (hit_pa_val) begin
        st_next.pa_val = reg_wdata;
      end else if (hit_pb_val) begin
        st_next.pb_val = reg_wdata;
      end else if (hit_pa_dir) begin
        st_next.pa_dir = reg_wdata;
      end else if (hit_pb_dir) begin
        st_next.pb_dir = reg_wdata;
      end else if (hit_pe_val) begin
        st_next.pe_val = reg_wdata;
      end else if (hit_pe_dir) begin
        st_next.pe_dir = reg_wdata & 8'hFC;
      end else if (hit_pe_asgn) begin
        st_next.pe_asgn = reg_wdata & `BPR_MSK_PE_ASGN;
      end else if (hit_mode) begin
        st_next.mode = reg_wdata & `BPR_MSK_MODE;
      end else if (hit_pull) begin
        st_next.pull = reg_wdata & `BPR_MSK_PULL;
      end else if (hit_rdrive) begin
        st_next.rdrive = reg_wdata & `BPR_MSK_RDRIVE;
      end else if (hit_ebus) begin
        st_next.ebus = reg_wdata & `BPR_MSK_EBUS;
      end else if (hit_irq_ctl) begin
        st_next.irq_ctl = reg_wdata & `BPR_MSK_IRQ_CTL;
      end else if (hit_pk_val) begin
        st_next.pk_val = reg_wdata;
      end else if (hit_pk_dir) begin
        st_next.pk_dir = reg_wdata;
      end
    end

    // Register reads; anything unlisted returns zero
    if (rd_ok) begin
      if (hit_pa_val) begin
        st_next.rdata = pa_rd_val;
      end else if (hit_pb_val) begin
        st_next.rdata = pb_rd_val;
      end else if (hit_pa_dir) begin
        st_next.rdata = st_reg.pa_dir;
      end else if (hit_pb_dir) begin
        st_next.rdata = st_reg.pb_dir;
      end else if (hit_pe_val) begin
        st_next.rdata = pe_rd_val;
      end else if (hit_pe_dir) begin
        st_next.rdata = st_reg.pe_dir;
      end else if (hit_pe_asgn) begin
        st_next.rdata = st_reg.pe_asgn;
      end else if (hit_mode) begin
        st_next.rdata = st_reg.mode;
      end else if (hit_pull) begin
        st_next.rdata = st_reg.pull;
      end else if (hit_rdrive) begin
        st_next.rdata = st_reg.rdrive;
      end else if (hit_ebus) begin
        st_next.rdata = st_reg.ebus;
      end else if (hit_irq_ctl) begin
        st_next.rdata = st_reg.irq_ctl;
      end else if (hit_pk_val) begin
        st_next.rdata = pk_rd_val;
      end else if (hit_pk_dir) begin
        st_next.rdata = st_reg.pk_dir;
      end else begin
        st_next.rdata = 8'h00;
      end
    end

    // External echo of accesses outside the on-chip map
    st_next.echo_rd    = reg_rd && unmapped;
    st_next.echo_wr    = reg_wr && unmapped;
    st_next.echo_ofs   = (reg_rd || reg_wr) && unmapped ? ofs : st_reg.echo_ofs;
    st_next.echo_wdata = reg_wr && unmapped ? reg_wdata : st_reg.echo_wdata;

    // Port E drive: bus function or general output latch
    st_next.pe_out     = pe_drv_val;
    st_next.pe_oe      = pe_drv_en;

    // Pulls on pull-capable pins only while they sense
    st_next.pe_pull_en = pe_pull_sel;

    // Interrupt request inputs on pins 1:0
    st_next.irq_req_n  = pe_in[1];
    st_next.nonmaskable_interrupt_request_req_n = pe_in[0];
  end

  // State register
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      st_reg            <= '0;
      st_reg.irq_ctl    <= `BPR_RST_IRQ_CTL;
      st_reg.mode       <= `BPR_RST_ZERO;
      st_reg.irq_req_n  <= 1'b1;
      st_reg.nonmaskable_interrupt_request_req_n <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // Read data and general port latches, straight from the state register
  assign reg_rdata     = st_reg.rdata;
  assign pa_out        = st_reg.pa_val;
  assign pa_oe         = st_reg.pa_dir;
  assign pb_out        = st_reg.pb_val;
  assign pb_oe         = st_reg.pb_dir;
  assign pk_out        = st_reg.pk_val;
  assign pk_oe         = st_reg.pk_dir;

  // Port E pads
  assign pe_out        = st_reg.pe_out;
  assign pe_oe         = st_reg.pe_oe;
  assign pe_pull_en    = st_reg.pe_pull_en;
  assign pe_pull_up    = PE_PULL_UP | 8'h03;

  // Interrupt requests and register contents
  assign irq_req_n     = st_reg.irq_req_n;
  assign nonmaskable_interrupt_request_req_n    = st_reg.nonmaskable_interrupt_request_req_n;
  assign mode_value    = st_reg.mode;
  assign rdrive_value  = st_reg.rdrive;
  assign ebus_value    = st_reg.ebus;
  assign irq_ctl_value = st_reg.irq_ctl;

  // External echo
  assign echo_rd       = st_reg.echo_rd;
  assign echo_wr       = st_reg.echo_wr;
  assign echo_ofs      = st_reg.echo_ofs;
  assign echo_wdata    = st_reg.echo_wdata;

endmodule : bpr_port_block

`default_nettype wire

// *** inc/bpr_defines.svh ***
// Offsets, field positions, reset values and write masks of the bus port block.
// Assumes byte-wide registers on a byte-addressed register port.
`ifndef BPR_DEFINES_SVH
`define BPR_DEFINES_SVH

// Register offsets from the module base
`define BPR_OFS_PA_VAL   6'h00
`define BPR_OFS_PB_VAL   6'h01
`define BPR_OFS_PA_DIR   6'h02
`define BPR_OFS_PB_DIR   6'h03
`define BPR_OFS_RSV_LO   6'h04
`define BPR_OFS_RSV_HI   6'h07
`define BPR_OFS_PE_VAL   6'h08
`define BPR_OFS_PE_DIR   6'h09
`define BPR_OFS_PE_ASGN  6'h0A
`define BPR_OFS_MODE     6'h0B
`define BPR_OFS_PULL     6'h0C
`define BPR_OFS_RDRIVE   6'h0D
`define BPR_OFS_EBUS     6'h0E
`define BPR_OFS_RSV_F    6'h0F
`define BPR_OFS_IRQ_CTL  6'h1E
`define BPR_OFS_PK_VAL   6'h32
`define BPR_OFS_PK_DIR   6'h33
`define BPR_SPAN         16'h0040

// Reset values
`define BPR_RST_ZERO     8'h00
`define BPR_RST_IRQ_CTL  8'h40

// Implemented bits; the rest read zero
`define BPR_MSK_PE_ASGN  8'h3C
`define BPR_MSK_MODE     8'hE3
`define BPR_MSK_PULL     8'hD3
`define BPR_MSK_RDRIVE   8'h93
`define BPR_MSK_EBUS     8'h01
`define BPR_MSK_IRQ_CTL  8'hC0

// Field positions
`define BPR_MODE_HI      7
`define BPR_MODE_LO      5
`define BPR_MODE_EME     1
`define BPR_ASGN_PIPE    5
`define BPR_ASGN_NOCLK   4
`define BPR_ASGN_STRB    3
`define BPR_ASGN_RW      2
`define BPR_PULL_PE      4

// Operating mode codes
`define BPR_MODE_SS      3'h0
`define BPR_MODE_NS      3'h4
`define BPR_MODE_PERIPH  3'h6

`endif

// *** inc/bpr_pkg.sv ***
// Types of the bus port block.
// Assumes bpr_defines.svh supplies the numeric constants.
package bpr_pkg;

  // Whole state of the block, registered as one word
  typedef struct packed {
    logic [7:0] pa_val;
    logic [7:0] pb_val;
    logic [7:0] pa_dir;
    logic [7:0] pb_dir;
    logic [7:0] pe_val;
    logic [7:0] pe_dir;
    logic [7:0] pe_asgn;
    logic [7:0] mode;
    logic [7:0] pull;
    logic [7:0] rdrive;
    logic [7:0] ebus;
    logic [7:0] irq_ctl;
    logic [7:0] pk_val;
    logic [7:0] pk_dir;
    logic [7:0] rdata;
    logic [7:0] pe_out;
    logic [7:0] pe_oe;
    logic [7:0] pe_pull_en;
    logic       irq_req_n;
    logic       nonmaskable_interrupt_request_req_n;
    logic       echo_rd;
    logic       echo_wr;
    logic [5:0] echo_ofs;
    logic [7:0] echo_wdata;
  } bpr_state_t;

endpackage : bpr_pkg

// *** verification/bpr_port_block_properties.sv ***
// Concurrent checks on the bus port block's ports.
// Assumes a one-cycle read answer and one-cycle echo pulses.
`timescale 1ns/1ns
`default_nettype none
module bpr_port_props #(
  parameter int ADDR_W = 16
) (
  input wire logic              core_clk,
  input wire logic              reset,
  input wire logic [ADDR_W-1:0] reg_base,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [7:0]        reg_wdata,
  input wire logic [7:0]        reg_rdata,
  input wire logic [7:0]        pe_in,
  input wire logic [7:0]        pe_oe,
  input wire logic [7:0]        pe_pull_en,
  input wire logic [7:0]        pe_pull_up,
  input wire logic [7:0]        mode_value,
  input wire logic              irq_req_n,
  input wire logic              echo_wr
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  // Access offset, and port E data access in single chip mode
  wire logic [ADDR_W-1:0] ofs = reg_addr - reg_base;
  wire logic pe_acc = (ofs == ADDR_W'(16'h0008)) && (mode_value == 8'h00);
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not zero outside answer cycle");
  a_rsvd_read: assert property (reg_rd && (ofs inside {[4:7], 15}) |=> reg_rdata == 8'h00)
    else $error("reserved location read not zero");
  a_low_inputs: assert property (pe_oe[1:0] == 2'h0)
    else $error("port E pins 1:0 driven");
  a_dir_drive: assert property (reg_wr && ofs == ADDR_W'(16'h0009)
    |-> ##2 pe_oe[7] == $past(reg_wdata[7], 2))
    else $error("port E pin 7 enable not per direction");
  a_pull_inputs: assert property ((pe_pull_en & pe_oe) == 8'h00)
    else $error("pull enabled on a driven pin");
  a_pull_pol: assert property (pe_pull_up[1:0] == 2'h3)
    else $error("interrupt pin pull not up");
  a_irq_follow: assert property (!$past(reset) |-> irq_req_n == $past(pe_in[1]))
    else $error("interrupt request not following pin");
  a_echo_wr: assert property (reg_wr && ofs == ADDR_W'(16'h0008)
    && mode_value[7:5] == 3'h6 |=> echo_wr)
    else $error("peripheral mode port E write not echoed");
  a_no_echo: assert property (reg_wr && pe_acc |=> !echo_wr)
    else $error("mapped port E write echoed");
  a_pin_read: assert property (reg_rd && pe_acc ##1 !pe_oe[7]
    |-> reg_rdata[7] == $past(pe_in[7]))
    else $error("input bit read not from pin");
  // Main scenarios
  c_pe_write: cover property (reg_wr && pe_acc);
  c_echo: cover property (echo_wr);
  c_pe_read: cover property (reg_rd && pe_acc);
endmodule : bpr_port_props
bind bpr_port_block bpr_port_props #(.ADDR_W(ADDR_W)) u_props (.core_clk(core_clk),
  .reset(reset), .reg_base(reg_base), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .pe_in(pe_in),
  .pe_oe(pe_oe), .pe_pull_en(pe_pull_en), .pe_pull_up(pe_pull_up),
  .mode_value(mode_value), .irq_req_n(irq_req_n), .echo_wr(echo_wr));
`default_nettype wire

// *** verification/bpr_pin_model.sv ***
// Pad model of port E: device drive, outside drivers, pulls, floating.
// Assumes the bench names per bit which pads an outside driver holds.
`timescale 1ns/1ns
`default_nettype none
module bpr_pin_model (
  input  wire logic       core_clk,
  input  wire logic [7:0] pe_out,
  input  wire logic [7:0] pe_oe,
  input  wire logic [7:0] pe_pull_en,
  input  wire logic [7:0] pe_pull_up,
  input  wire logic [7:0] ext_drv,
  input  wire logic [7:0] ext_val,
  output logic      [7:0] pe_in
);
  logic [7:0] last_reg = 8'h00;
  // A floating pad flips every cycle
  always @(posedge core_clk) last_reg <= pe_in;
  // Device drive first, then outside drive, then pull
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pe_oe[i]) pe_in[i] = pe_out[i];
      else if (ext_drv[i]) pe_in[i] = ext_val[i];
      else if (pe_pull_en[i]) pe_in[i] = pe_pull_up[i];
      else pe_in[i] = ~last_reg[i];
    end
  end
endmodule : bpr_pin_model
`default_nettype wire

// *** verification/tb_top.sv ***
// Self-checking bench for the bus port block.
// Assumes the pad model on port E and a 10 MHz core clock.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic core_clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [15:0] reg_base = 16'h0100, reg_addr = 16'h0000;
  logic [7:0] reg_wdata = 8'h00, pa_in = 8'h00, pb_in = 8'h00, pk_in = 8'h00;
  logic [7:0] ext_drv = 8'h00, ext_val = 8'h00, d;
  logic [1:0] bus_pipe = 2'h0;
  logic bus_eclk = 1'b0, bus_strobe_n = 1'b1, bus_rw = 1'b1;
  logic [7:0] reg_rdata, pe_in, pe_out, pe_oe, pe_pull_en, pe_pull_up, echo_wdata;
  logic irq_req_n, nonmaskable_interrupt_request_req_n, echo_rd, echo_wr;
  logic [5:0] echo_ofs;
  logic [7:0] pa_out, pa_oe, pb_out, pb_oe, pk_out, pk_oe;
  logic [7:0] mode_value, rdrive_value, ebus_value, irq_ctl_value;
  int err_total = 0, samples_checked = 0;
  // Offset, write data, read back
  logic [23:0] rows [17] = '{24'h02FFFF, 24'h00A5A5, 24'h03FFFF, 24'h013C3C,
    24'h33FFFF, 24'h325A5A, 24'h04FF00, 24'h07FF00, 24'h0FFF00, 24'h10FF00,
    24'h0AFF3C, 24'h0A1010, 24'h0CFFD3, 24'h0DFF93, 24'h0EFF01, 24'h1EFFC0, 24'h09FFFC};
  bpr_port_block dut (.core_clk(core_clk), .reset(reset), .reg_base(reg_base),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .pa_in(pa_in), .pa_out(pa_out), .pa_oe(pa_oe),
    .pb_in(pb_in), .pb_out(pb_out), .pb_oe(pb_oe), .pk_in(pk_in), .pk_out(pk_out),
    .pk_oe(pk_oe), .pe_in(pe_in),
    .pe_out(pe_out), .pe_oe(pe_oe), .pe_pull_en(pe_pull_en), .pe_pull_up(pe_pull_up),
    .bus_pipe(bus_pipe), .bus_eclk(bus_eclk), .bus_strobe_n(bus_strobe_n),
    .bus_rw(bus_rw), .irq_req_n(irq_req_n), .nonmaskable_interrupt_request_req_n(nonmaskable_interrupt_request_req_n),
    .mode_value(mode_value), .rdrive_value(rdrive_value), .ebus_value(ebus_value),
    .irq_ctl_value(irq_ctl_value),
    .echo_rd(echo_rd), .echo_wr(echo_wr), .echo_ofs(echo_ofs), .echo_wdata(echo_wdata));
  bpr_pin_model pads (.core_clk(core_clk), .pe_out(pe_out), .pe_oe(pe_oe),
    .pe_pull_en(pe_pull_en), .pe_pull_up(pe_pull_up), .ext_drv(ext_drv),
    .ext_val(ext_val), .pe_in(pe_in));
  // Clock and hang guard
  initial forever #50 core_clk = ~core_clk;
  initial begin
    repeat (5000) @(posedge core_clk);
    err_total++;
    test_done();
  end
  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      err_total++;
    end
  endtask : chk
  // One write cycle; returns at the edge that takes it
  task automatic wr(input logic [7:0] o, input logic [7:0] v);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= reg_base + 16'(o);
    reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr
  // One read cycle; data taken inside the answer cycle
  task automatic rd(input logic [7:0] o, output logic [7:0] v);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= reg_base + 16'(o);
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : test_done
  initial begin
    repeat (3) @(posedge core_clk);
    reset <= 1'b0;
    foreach (rows[i]) begin
      rd(rows[i][23:16], d);
      chk("reset value", d, (rows[i][23:16] == 8'h1E) ? 8'h40 : 8'h00);
    end
    foreach (rows[i]) begin
      wr(rows[i][23:16], rows[i][15:8]);
      rd(rows[i][23:16], d);
      chk("readback", d, rows[i][7:0]);
    end
    chk("pa latch", pa_out, 8'hA5);
    chk("pa drive", pa_oe, 8'hFF);
    chk("pb latch", pb_out, 8'h3C);
    chk("pb drive", pb_oe, 8'hFF);
    chk("pk latch", pk_out, 8'h5A);
    chk("pk drive", pk_oe, 8'hFF);
    chk("rdrive value", rdrive_value, 8'h93);
    chk("ebus value", ebus_value, 8'h01);
    chk("irq ctl value", irq_ctl_value, 8'hC0);
    $display("test registers done");
    ext_drv <= 8'h0F;
    ext_val <= 8'h0A;
    wr(8'h08, 8'h5C);
    wr(8'h09, 8'hF0);
    rd(8'h08, d);
    chk("pe read mix", d, 8'h5A);
    chk("pe drive", pe_oe, 8'hF0);
    chk("pe latch", pe_out & 8'hF0, 8'h50);
    chk("pull inputs", pe_pull_en, 8'h0F);
    ext_drv <= 8'h00;
    wr(8'h09, 8'h00);
    rd(8'h08, d);
    chk("pulled pins", d & 8'h9F, 8'h9F);
    wr(8'h0C, 8'h00);
    @(posedge core_clk);
    #1 chk("pull off", pe_pull_en, 8'h00);
    $display("test port e general done");
    bus_pipe <= 2'h2;
    bus_strobe_n <= 1'b0;
    bus_eclk <= 1'b1;
    wr(8'h0A, 8'h2C);
    @(posedge core_clk);
    #1 chk("special drive", pe_oe & 8'h7C, 8'h7C);
    chk("special level", pe_out & 8'h7C, 8'h54);
    ext_drv <= 8'h03;
    ext_val <= 8'h01;
    wr(8'h0A, 8'h10);
    chk("irq pins", {6'h00, irq_req_n, nonmaskable_interrupt_request_req_n}, 8'h01);
    $display("test port e special done");
    wr(8'h09, 8'hFC);
    wr(8'h0B, 8'hC0);
    chk("mode value", mode_value, 8'hC0);
    wr(8'h08, 8'h33);
    chk("echo write", {echo_wr, 1'b0, echo_ofs}, 8'h88);
    chk("echo data", echo_wdata, 8'h33);
    rd(8'h04, d);
    chk("echo reserved", {echo_rd, d[6:0]}, 8'h80);
    wr(8'h0B, 8'h22);
    wr(8'h08, 8'h44);
    chk("echo emulation", {7'h00, echo_wr}, 8'h01);
    wr(8'h0B, 8'h20);
    wr(8'h08, 8'h66);
    chk("no echo", {7'h00, echo_wr}, 8'h00);
    rd(8'h08, d);
    chk("expanded pe", d, 8'h65);
    $display("test echo done");
    reg_base <= 16'h2000;
    rd(8'h1E, d);
    chk("relocated", d, 8'hC0);
    rd(8'h40, d);
    chk("out of span", d, 8'h00);
    reset <= 1'b1;
    @(posedge core_clk);
    reset <= 1'b0;
    rd(8'h0B, d);
    chk("mode after reset", d, 8'h00);
    chk("irq ctl after reset", irq_ctl_value, 8'h40);
    $display("test relocation and reset done");
    test_done();
  end
endmodule : tb_top
`default_nettype wire
